// ===== hw/dcwd_defs.svh
// Constants for the disk card watchdog and write protect block
`ifndef DCWD_DEFS_SVH
`define DCWD_DEFS_SVH

`define DCWD_OFS_WP         2'h0
`define DCWD_OFS_WD         2'h3
`define DCWD_WP_SET         8'h80
`define DCWD_WP_CLR         8'h00
`define DCWD_WD_OFF         8'h00
`define DCWD_WD_BASE        5'h10
`define DCWD_CLK_HZ         25000000
`define DCWD_HALF_UNIT_S    3
`define DCWD_HALF_UNIT_CYC  (`DCWD_CLK_HZ * `DCWD_HALF_UNIT_S)
`define DCWD_RST_PULSE_NS   1000
`define DCWD_RST_PULSE_CYC  ((`DCWD_RST_PULSE_NS + 39) / 40)
`define DCWD_BLINK_HALVES   4'h1

`endif

// ===== hw/dcwd_pkg.sv
// Types for the disk card watchdog and write protect block
package dcwd_pkg;
	typedef struct packed {
		logic       wr;
		logic [1:0] ofs;
		logic [7:0] data;
	} dcwd_io_wr_t;

	typedef struct packed {
		logic flash_wr;
		logic sram_wr;
	} dcwd_mem_wr_t;

	typedef enum logic [1:0] {
		DCWD_IDLE  = 2'b00,
		DCWD_COUNT = 2'b01,
		DCWD_FIRE  = 2'b10
	} dcwd_state_t;
endpackage : dcwd_pkg

// ===== hw/dcwd_tick.sv
// Half-unit time base divider: one enable pulse per half unit
`timescale 1ns/1ps
`default_nettype none
`include "dcwd_defs.svh"
module dcwd_tick
	import dcwd_pkg::*;
#(
	parameter int unsigned HALF_CYC = `DCWD_HALF_UNIT_CYC
)(
	input  wire logic ref_clk_i,
	input  wire logic rst_n_i,
	input  wire logic clr_i,
	output logic      tick_o
);
	logic [31:0] cnt_q;

	// Restart on clear so a trigger realigns the time base
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			cnt_q <= 32'h0;
		else if (clr_i || cnt_q == HALF_CYC - 1)
			cnt_q <= 32'h0;
		else
			cnt_q <= cnt_q + 32'h1;
	end

	assign tick_o = !clr_i && (cnt_q == HALF_CYC - 1);
endmodule : dcwd_tick
`default_nettype wire

// ===== hw/dcwd_top.sv
// Watchdog timer and write protect control of the disk card
`timescale 1ns/1ps
`default_nettype none
`include "dcwd_defs.svh"
module dcwd_top
	import dcwd_pkg::*;
#(
	parameter int unsigned HALF_CYC = `DCWD_HALF_UNIT_CYC
)(
	input  wire logic         ref_clk_i,
	input  wire logic         rst_n_i,
	input  wire dcwd_io_wr_t  io_i,
	input  wire dcwd_mem_wr_t mem_wr_i,
	input  wire logic         protect_select_switch_a_i,
	input  wire logic         protect_select_switch_b_i,
	output logic              flash_wr_en_o,
	output logic              sram_wr_en_o,
	output logic              wr_refused_o,
	output logic              sys_reset_o,
	output logic              wd_led_o
);
	////////////////////////////////////////////////////////////////////////
	// Overview
	// Two concerns share the host port decode. The protect half gates the
	// disk memory write strobes combinationally, so a refused write never
	// reaches an array, not even for one cycle. The watchdog half counts
	// half units from a divider enable, so one fast clock serves both and
	// there is no second clock domain to cross.
	// Limitation: a half unit is an exact cycle count, so every time-out
	// is only as accurate as the reference clock.
	// The reset pulse ends in the disabled state, so software that keeps
	// running after the pulse must enable the watchdog again.
	// Writes to offsets one and two are not decoded here.

	// Watchdog state and timing
	dcwd_state_t state_q;
	logic [2:0]  factor_q;
	logic [3:0]  halves_q;
	logic [3:0]  limit_d;
	logic [5:0]  pulse_q;
	logic        tick;
	// LED blinker
	logic [3:0]  blink_q;
	logic        led_q;
	// Protection
	logic        sw_wp_q;
	logic        refused_q;
	logic        hw_wp;
	logic        flash_wp;
	// Port decode
	logic        wp_wr;
	logic        wd_wr;
	logic        wd_valid;
	logic        wd_off;

	// Time-out expressed in half units: code 0 is one half, else 2*code
	function automatic logic [3:0] dcwd_limit(input logic [2:0] f);
		if (f == 3'h0)
			return 4'h1;
		return {f, 1'b0};
	endfunction : dcwd_limit

	// Write strobe aimed at one port offset; shared by both decoders
	function automatic logic dcwd_hit(input dcwd_io_wr_t io,
		input logic [1:0] ofs);
		return io.wr && io.ofs == ofs;
	endfunction : dcwd_hit

	////////////////////////////////////////////////////////////////////////
	// Port decode
	// Only full codes are decoded; stray bytes fall through untouched
	assign wp_wr    = dcwd_hit(io_i, `DCWD_OFS_WP);
	assign wd_wr    = dcwd_hit(io_i, `DCWD_OFS_WD);
	assign wd_valid = wd_wr && io_i.data[7:3] == `DCWD_WD_BASE;
	assign wd_off   = wd_wr && io_i.data == `DCWD_WD_OFF;
	assign limit_d  = dcwd_limit(factor_q);

	// Software protect latch; other data codes leave it alone
	// Reset clears it, so protection must be set again after any reset
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			sw_wp_q <= 1'b0;
		else if (wp_wr)
		begin
			if (io_i.data == `DCWD_WP_SET)
				sw_wp_q <= 1'b1;
			else if (io_i.data == `DCWD_WP_CLR)
				sw_wp_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Protection gating
	// Enables are combinational so a blocked strobe is never seen by the
	// array; the switch pair guards flash only, the latch guards both
	assign hw_wp    = protect_select_switch_a_i && !protect_select_switch_b_i;
	assign flash_wp = sw_wp_q || hw_wp;
	assign flash_wr_en_o = mem_wr_i.flash_wr && !flash_wp;
	assign sram_wr_en_o  = mem_wr_i.sram_wr && !sw_wp_q;

	// Refusal flag, held one cycle so the disk firmware can sample it
	// Registered so the flag cannot glitch with the request decode
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			refused_q <= 1'b0;
		else
			refused_q <= (mem_wr_i.flash_wr && flash_wp) ||
				(mem_wr_i.sram_wr && sw_wp_q);
	end
	assign wr_refused_o = refused_q;

	////////////////////////////////////////////////////////////////////////
	// Time base restarts on every valid watchdog write
	// Without the restart a trigger could see a tick almost at once
	dcwd_tick #(
		.HALF_CYC (HALF_CYC)
	) u_tick (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.clr_i     (wd_valid || wd_off),
		.tick_o    (tick)
	);

	// Watchdog state; unlisted codes are ignored entirely
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			state_q <= DCWD_IDLE;
		else
		begin
			unique case (state_q)
				// Only a listed code enables; anything else is ignored
				DCWD_IDLE:
					if (wd_valid)
						state_q <= DCWD_COUNT;
				// A trigger outranks a time-out landing in the same cycle
				DCWD_COUNT:
					if (wd_off)
						state_q <= DCWD_IDLE;
					else if (!wd_valid && tick && halves_q + 4'h1 >= limit_d)
						state_q <= DCWD_FIRE;
				// Pulse length is fixed; writes are ignored until it ends
				DCWD_FIRE:
					if (pulse_q == 6'(`DCWD_RST_PULSE_CYC - 1))
						state_q <= DCWD_IDLE;
				default:
					state_q <= DCWD_IDLE;
			endcase
		end
	end

	// Factor register; new code governs the interval it starts
	// Only listed codes load it, so a stray byte cannot alter a period
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			factor_q <= 3'h0;
		else if (wd_valid)
			factor_q <= io_i.data[2:0];
	end

	// Elapsed half units, cleared by a trigger
	// Held at zero outside counting so every enable starts clean
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			halves_q <= 4'h0;
		else if (wd_valid || wd_off || state_q != DCWD_COUNT)
			halves_q <= 4'h0;
		else if (tick)
			halves_q <= halves_q + 4'h1;
	end

	// Fixed width reset pulse
	// Counts only while firing; the state machine ends the pulse
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pulse_q <= 6'h0;
		else if (state_q == DCWD_FIRE)
			pulse_q <= pulse_q + 6'h1;
		else
			pulse_q <= 6'h0;
	end
	assign sys_reset_o = state_q == DCWD_FIRE;

	////////////////////////////////////////////////////////////////////////
	// LED lit at enable and on every trigger, then toggled each half unit
	// while counting; dark from the cycle after a disable, and from the second cycle of a reset pulse
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			led_q   <= 1'b0;
			blink_q <= 4'h0;
		end
		else if (wd_valid && state_q != DCWD_FIRE)
		begin
			led_q   <= 1'b1;
			blink_q <= 4'h0;
		end
		else if (state_q != DCWD_COUNT || wd_off)
		begin
			led_q   <= 1'b0;
			blink_q <= 4'h0;
		end
		else if (tick)
		begin
			if (blink_q + 4'h1 >= `DCWD_BLINK_HALVES)
			begin
				led_q   <= !led_q;
				blink_q <= 4'h0;
			end
			else
				blink_q <= blink_q + 4'h1;
		end
	end
	assign wd_led_o = led_q;
endmodule : dcwd_top
`default_nettype wire

// ===== tb/dcwd_checker.sv
// Port checker for the watchdog and protect block
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
module dcwd_checker
	import dcwd_pkg::*;
#(
	parameter int unsigned HALF_CYC = 4
)(
	input wire logic         ref_clk_i,
	input wire logic         rst_n_i,
	input wire dcwd_io_wr_t  io_i,
	input wire dcwd_mem_wr_t mem_wr_i,
	input wire logic         protect_select_switch_a_i,
	input wire logic         protect_select_switch_b_i,
	input wire logic         flash_wr_en_o,
	input wire logic         sram_wr_en_o,
	input wire logic         wr_refused_o,
	input wire logic         sys_reset_o,
	input wire logic         wd_led_o
);
	// One clock domain, so clocking and reset are shared
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Port decodes of the two written registers
	wire p0 = io_i.wr && io_i.ofs == 2'h0;
	wire p3 = io_i.wr && io_i.ofs == 2'h3;
	flash_gate_a: assert property (flash_wr_en_o |-> mem_wr_i.flash_wr)
		else $error("flash enable without request");
	switch_lock_a: assert property (protect_select_switch_a_i &&
		!protect_select_switch_b_i |-> !flash_wr_en_o) else $error("switch");
	prot_set_a: assert property (p0 && io_i.data == 8'h80 |=>
		!sram_wr_en_o && !flash_wr_en_o) else $error("protect not set");
	prot_clr_a: assert property (p0 && io_i.data == 8'h00 |=>
		sram_wr_en_o == mem_wr_i.sram_wr) else $error("protect not cleared");
	refuse_flag_a: assert property (mem_wr_i.sram_wr && !sram_wr_en_o
		|=> wr_refused_o) else $error("refusal not flagged");
	wd_start_a: assert property (p3 && io_i.data[7:3] == 5'h10 &&
		!sys_reset_o |=> wd_led_o) else $error("led dark after enable");
	wd_stop_a: assert property (p3 && io_i.data == 8'h00 &&
		!sys_reset_o |=> !wd_led_o ##1 !sys_reset_o)
		else $error("watchdog not stopped");
	pulse_hold_a: assert property ($rose(sys_reset_o) |=>
		sys_reset_o [*8]) else $error("reset pulse too short");
endmodule : dcwd_checker
`default_nettype wire
////////////////////////////////////////////////////////////////
bind dcwd_top dcwd_checker #(.HALF_CYC(HALF_CYC)) u_dcwd_checker (
	.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .io_i(io_i),
	.mem_wr_i(mem_wr_i), .flash_wr_en_o(flash_wr_en_o),
	.protect_select_switch_a_i(protect_select_switch_a_i),
	.protect_select_switch_b_i(protect_select_switch_b_i),
	.sram_wr_en_o(sram_wr_en_o), .wr_refused_o(wr_refused_o),
	.sys_reset_o(sys_reset_o), .wd_led_o(wd_led_o));

// ===== tb/dcwd_host.sv
// Host model issuing byte writes to the card ports
`timescale 1ns/1ps
`default_nettype none
module dcwd_host
	import dcwd_pkg::*;
(
	input wire logic        ref_clk_i,
	output var dcwd_io_wr_t io_o
);
	// Bus idle at start
	initial io_o = '0;
	// One strobed byte; data inverted once released so stale bytes show
	task automatic wr(input logic [1:0] ofs, input logic [7:0] d);
		@(negedge ref_clk_i);
		io_o = '{1'b1, ofs, d};
		@(negedge ref_clk_i);
		io_o = '{1'b0, ofs, ~d};
	endtask : wr
endmodule : dcwd_host
`default_nettype wire

// ===== tb/dcwd_top_tb.sv
// Self-checking bench for the watchdog and protect block
`timescale 1ns/1ps
`default_nettype none
module dcwd_top_tb;
	import dcwd_pkg::*;
	localparam int H = 4;
	logic         clk, rst_n, sw_a, sw_b, fl, sr, rf, sy, led;
	dcwd_io_wr_t  io;
	dcwd_mem_wr_t mem;
	int           err_total, check_count, cyc, n, w, i;
	dcwd_host u_dcwd_host (.ref_clk_i(clk), .io_o(io));
	dcwd_top #(.HALF_CYC(H)) u_dcwd_top (.ref_clk_i(clk), .rst_n_i(rst_n),
		.io_i(io), .mem_wr_i(mem), .protect_select_switch_a_i(sw_a),
		.protect_select_switch_b_i(sw_b), .flash_wr_en_o(fl),
		.sram_wr_en_o(sr), .wr_refused_o(rf), .sys_reset_o(sy),
		.wd_led_o(led));
	////////////////////////////////////////////////////////////////
	// Clock, and a ceiling so a hang still reaches the verdict
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_total++;
			finish_test();
		end
	end
	task finish_test();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Cycles from the write to the pulse equal the half units times H
	task automatic wd_run(input logic [7:0] code, input int exp);
		u_dcwd_host.wr(2'h3, code);
		n = 0;
		w = 0;
		while (!sy && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		while (sy && w < 50)
		begin
			@(negedge clk);
			w++;
		end
		chk(8'(n), 8'(exp));
		chk(8'(w), 8'h19);
		chk({7'h0, led}, 8'h00);
	endtask : wd_run
	////////////////////////////////////////////////////////////////
	// Main sequence: protect paths first, then the watchdog
	initial
	begin
		{rst_n, sw_a, sw_b, mem} = '0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		repeat (20) @(negedge clk);
		chk({6'h0, sy, led}, 8'h00);
		mem = 2'b11;
		sw_a = 1'b1;
		#1 chk({6'h0, fl, sr}, 8'h01);
		@(negedge clk);
		sw_b = 1'b1;
		#1 chk({6'h0, fl, sr}, 8'h03);
		u_dcwd_host.wr(2'h0, 8'h80);
		@(negedge clk);
		chk({5'h0, fl, sr, rf}, 8'h01);
		u_dcwd_host.wr(2'h0, 8'h55);
		chk({6'h0, fl, sr}, 8'h00);
		u_dcwd_host.wr(2'h0, 8'h00);
		chk({6'h0, fl, sr}, 8'h03);
		mem = 2'b00;
		u_dcwd_host.wr(2'h3, 8'h9A);
		chk({7'h0, led}, 8'h00);
		u_dcwd_host.wr(2'h3, 8'h87);
		repeat (4) @(negedge clk);
		chk({7'h0, led}, 8'h00);
		repeat (4) @(negedge clk);
		chk({7'h0, led}, 8'h01);
		for (i = 0; i < 8; i++)
			wd_run(8'(8'h80 + i), (i == 0 ? 1 : 2 * i) * H);
		u_dcwd_host.wr(2'h3, 8'h81);
		repeat (4)
		begin
			repeat (4) @(negedge clk);
			u_dcwd_host.wr(2'h3, 8'h81);
		end
		chk({7'h0, sy}, 8'h00);
		u_dcwd_host.wr(2'h3, 8'h00);
		repeat (10) @(negedge clk);
		chk({6'h0, sy, led}, 8'h00);
		// Mid-run reset while counting must leave the watchdog disabled
		u_dcwd_host.wr(2'h3, 8'h81);
		rst_n = 1'b0;
		@(negedge clk);
		rst_n = 1'b1;
		repeat (12) @(negedge clk);
		chk({6'h0, sy, led}, 8'h00);
		finish_test();
	end
endmodule : dcwd_top_tb
`default_nettype wire
